// file: rtl/rtcf_pkg.sv
// Constants shared by the event flag and reset command logic
package rtcf_pkg;

   // ==========================================================
   // Widths and register file extent
   localparam int ADDR_W    = 7;
   localparam int DATA_W    = 8;
   localparam int REG_COUNT = 46;   // Bytes 00h up to 2Dh

   // ==========================================================
   // Register addresses
   localparam logic [6:0] ADDR_HUNDREDTHS = 7'h00;
   localparam logic [6:0] ADDR_SECONDS    = 7'h01;
   localparam logic [6:0] ADDR_MINUTES    = 7'h02;
   localparam logic [6:0] ADDR_DAYS       = 7'h04;
   localparam logic [6:0] ADDR_WEEKDAYS   = 7'h05;
   localparam logic [6:0] ADDR_MONTHS     = 7'h06;
   localparam logic [6:0] ADDR_ALARM_LO   = 7'h08;
   localparam logic [6:0] ADDR_ALARM_HI   = 7'h0F;
   localparam logic [6:0] ADDR_CAPTURE_LO = 7'h11;
   localparam logic [6:0] ADDR_CAPTURE_HI = 7'h22;
   localparam logic [6:0] ADDR_OSC_CTRL   = 7'h25;
   localparam logic [6:0] ADDR_BATT_CTRL  = 7'h26;
   localparam logic [6:0] ADDR_PIN_IO     = 7'h27;
   localparam logic [6:0] ADDR_FUNCTION   = 7'h28;
   localparam logic [6:0] ADDR_EVENT_FLAG = 7'h2B;   // event_flag_status
   localparam logic [6:0] ADDR_RESET_CMD  = 7'h2F;   // reset_command

   // ==========================================================
   // Reset values
   localparam logic [7:0] RST_SECONDS  = 8'h80;
   localparam logic [7:0] RST_DAYS     = 8'h01;
   localparam logic [7:0] RST_WEEKDAYS = 8'h06;      // Saturday
   localparam logic [7:0] RST_MONTHS   = 8'h01;
   localparam logic [7:0] RST_DEFAULT  = 8'h00;
   localparam logic [7:0] RST_FLAGS    = 8'h00;

   // ==========================================================
   // Flag bit positions in event_flag_status
   localparam int BIT_PERIODIC_TICK  = 7;
   localparam int BIT_SECOND_ALARM   = 6;
   localparam int BIT_FIRST_ALARM    = 5;
   localparam int BIT_WATCHDOG       = 4;
   localparam int BIT_SUPPLY_SWITCH  = 3;
   localparam int BIT_CAPTURE_3      = 2;
   localparam int BIT_CAPTURE_2      = 1;
   localparam int BIT_CAPTURE_1      = 0;
   localparam int BIT_EVENT_MONITOR  = 7;            // In the minutes byte

   // ==========================================================
   // Reset command codes
   localparam logic [7:0] CMD_SOFT_RESET      = 8'h2C;
   localparam logic [7:0] CMD_PRESCALER_CLEAR = 8'hA4;
   localparam logic [7:0] CMD_CAPTURE_CLEAR   = 8'h25;
   localparam logic [7:0] CMD_BOTH_CLEAR      = 8'hA5;

endpackage : rtcf_pkg

// file: rtl/rtcf_cmd_decode.sv
// Decoder for the write-only reset command byte
`timescale 1ns/1ps
`default_nettype none

module rtcf_cmd_decode
   import rtcf_pkg::*;
(
   input  wire logic        strobe_in,
   input  wire logic [7:0]  code_in,
   output logic             soft_reset_out,
   output logic             prescaler_clear_out,
   output logic             capture_clear_out
);

   // ==========================================================
   // Code decode
   // Exact codes only, anything else gives no action
   always_comb
   begin
      soft_reset_out      = 1'b0;
      prescaler_clear_out = 1'b0;
      capture_clear_out   = 1'b0;
      if (strobe_in)
      begin
         case (code_in)
            CMD_SOFT_RESET:
            begin
               soft_reset_out      = 1'b1;
               prescaler_clear_out = 1'b1;
               capture_clear_out   = 1'b1;
            end
            CMD_PRESCALER_CLEAR:
               prescaler_clear_out = 1'b1;
            CMD_CAPTURE_CLEAR:
               capture_clear_out   = 1'b1;
            CMD_BOTH_CLEAR:
            begin
               prescaler_clear_out = 1'b1;
               capture_clear_out   = 1'b1;
            end
            default:
            begin
               soft_reset_out      = 1'b0;
               prescaler_clear_out = 1'b0;
               capture_clear_out   = 1'b0;
            end
         endcase
      end
   end

endmodule : rtcf_cmd_decode

`default_nettype wire

// file: rtl/rtcf_event_flags.sv
// Event flag register, reset command handling and reset-valued register bank
`timescale 1ns/1ps
`default_nettype none

module rtcf_event_flags
   import rtcf_pkg::*;
(
   input  wire logic                 clk_in,
   input  wire logic                 reset_in,
   input  wire logic                 wr_en_in,
   input  wire logic                 rd_en_in,
   input  wire logic [ADDR_W-1:0]    addr_in,
   input  wire logic [DATA_W-1:0]    wr_data_in,
   input  wire logic [7:0]           event_set_in,
   output logic      [DATA_W-1:0]    rd_data_out,
   output logic      [7:0]           flags_out,
   output logic                      event_monitor_out,
   output logic                      soft_reset_out,
   output logic                      prescaler_clear_out,
   output logic                      capture_clear_out,
   output logic      [7:0]           function_ctrl_out,
   output logic      [7:0]           pin_io_out,
   output logic      [7:0]           osc_ctrl_out,
   output logic      [7:0]           battery_switch_out
);

   // ==========================================================
   // State
   typedef struct packed {
      logic [REG_COUNT-1:0][7:0] regs;
      logic [DATA_W-1:0]         rd_data;
      logic                      soft_reset;
      logic                      prescaler_clear;
      logic                      capture_clear;
   } rtcf_state_t;

   rtcf_state_t st;
   rtcf_state_t next_st;

   logic        cmd_strobe;
   logic        dec_soft_reset;
   logic        dec_prescaler_clear;
   logic        dec_capture_clear;
   logic        any_reset;
   logic [7:0]  flag_now;

   // ==========================================================
   // Helpers
   // Reset value of a byte in the bank
   function automatic logic [7:0] reset_value(input logic [ADDR_W-1:0] a);
      case (a)
         ADDR_SECONDS:    reset_value = RST_SECONDS;
         ADDR_DAYS:       reset_value = RST_DAYS;
         ADDR_WEEKDAYS:   reset_value = RST_WEEKDAYS;
         ADDR_MONTHS:     reset_value = RST_MONTHS;
         ADDR_EVENT_FLAG: reset_value = RST_FLAGS;
         default:         reset_value = RST_DEFAULT;
      endcase
   endfunction : reset_value

   // Address lies in the alarm setting range
   function automatic logic is_alarm(input logic [ADDR_W-1:0] a);
      is_alarm = (a >= ADDR_ALARM_LO) && (a <= ADDR_ALARM_HI);
   endfunction : is_alarm

   // Address lies in the capture register range
   function automatic logic is_capture(input logic [ADDR_W-1:0] a);
      is_capture = (a >= ADDR_CAPTURE_LO) && (a <= ADDR_CAPTURE_HI);
   endfunction : is_capture

   // ==========================================================
   // Command decode
   assign cmd_strobe = wr_en_in && (addr_in == ADDR_RESET_CMD);

   rtcf_cmd_decode u_cmd_decode (
      .strobe_in           (cmd_strobe),
      .code_in             (wr_data_in),
      .soft_reset_out      (dec_soft_reset),
      .prescaler_clear_out (dec_prescaler_clear),
      .capture_clear_out   (dec_capture_clear)
   );

   // Power-on and soft reset take the same path
   assign any_reset = reset_in || dec_soft_reset;
   assign flag_now  = st.regs[ADDR_EVENT_FLAG];

   // ==========================================================
   // Next state
   always_comb
   begin
      next_st = st;
      next_st.rd_data = st.rd_data;
      // Ordinary byte writes, flag byte handled apart
      if (wr_en_in && (addr_in < ADDR_W'(REG_COUNT)) && (addr_in != ADDR_EVENT_FLAG))
         next_st.regs[addr_in] = wr_data_in;
      // Flag byte: AND on write, then events OR in
      if (wr_en_in && (addr_in == ADDR_EVENT_FLAG))
         next_st.regs[ADDR_EVENT_FLAG] = flag_now & wr_data_in;
      next_st.regs[ADDR_EVENT_FLAG] = next_st.regs[ADDR_EVENT_FLAG]
                                    | event_set_in;
      // Capture bytes zeroed by the clear action
      if (dec_capture_clear)
      begin
         for (int i = 0; i < REG_COUNT; i++)
         begin
            if (is_capture(ADDR_W'(i)))
               next_st.regs[i] = RST_DEFAULT;
         end
      end
      // Full reset, alarm bytes kept
      if (any_reset)
      begin
         for (int i = 0; i < REG_COUNT; i++)
         begin
            if (!is_alarm(ADDR_W'(i)))
               next_st.regs[i] = reset_value(ADDR_W'(i));
         end
      end
      // Read data, minutes MSB carries the event monitor
      if (reset_in)
         next_st.rd_data = RST_DEFAULT;
      else if (rd_en_in)
      begin
         if (addr_in == ADDR_MINUTES)
            next_st.rd_data = {|flag_now, st.regs[ADDR_MINUTES][6:0]};
         else if (addr_in < ADDR_W'(REG_COUNT))
            next_st.rd_data = st.regs[addr_in];
         else
            next_st.rd_data = RST_DEFAULT;
      end
      // Action pulses, one cycle each
      next_st.soft_reset      = dec_soft_reset && !reset_in;
      next_st.prescaler_clear = dec_prescaler_clear && !reset_in;
      next_st.capture_clear   = dec_capture_clear && !reset_in;
      // Power-on reset also issues both clear actions
      if (reset_in)
      begin
         next_st.prescaler_clear = 1'b1;
         next_st.capture_clear   = 1'b1;
      end
   end

   // ==========================================================
   // State register
   always_ff @(posedge clk_in)
   begin
      st <= next_st;
   end

   // ==========================================================
   // Outputs
   assign rd_data_out         = st.rd_data;
   assign flags_out           = st.regs[ADDR_EVENT_FLAG];
   assign event_monitor_out   = |st.regs[ADDR_EVENT_FLAG];
   assign soft_reset_out      = st.soft_reset;
   assign prescaler_clear_out = st.prescaler_clear;
   assign capture_clear_out   = st.capture_clear;
   assign function_ctrl_out   = st.regs[ADDR_FUNCTION];
   assign pin_io_out          = st.regs[ADDR_PIN_IO];
   assign osc_ctrl_out        = st.regs[ADDR_OSC_CTRL];
   assign battery_switch_out  = st.regs[ADDR_BATT_CTRL];

   // ==========================================================
   // Assertions
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (reset_in);

   logic cmd_wr;
   logic flag_wr;
   assign cmd_wr  = wr_en_in && (addr_in == ADDR_RESET_CMD);
   assign flag_wr = wr_en_in && (addr_in == ADDR_EVENT_FLAG);

   // Soft reset write, which is allowed to wipe a coinciding event
   logic soft_cmd;
   assign soft_cmd = cmd_wr && (wr_data_in == CMD_SOFT_RESET);

   // A one-cycle pulse then low
   sequence s_pulse_soft;
      soft_reset_out ##1 !soft_reset_out;
   endsequence

   sequence s_pulse_both;
      (prescaler_clear_out && capture_clear_out) ##1 (!prescaler_clear_out && !capture_clear_out);
   endsequence

   // No action pulse at all in this cycle
   sequence s_no_action;
      !soft_reset_out && !prescaler_clear_out && !capture_clear_out;
   endsequence

   a_flag_and_write: assert property (
      (flag_wr && !cmd_wr && event_set_in == 8'h00)
      |=> flags_out == ($past(flags_out) & $past(wr_data_in)))
      else $error("flag write did not store AND of byte and flags");

   a_flag_set_wins: assert property (
      (event_set_in != 8'h00 && !soft_cmd)
      |=> ((flags_out & $past(event_set_in)) == $past(event_set_in)))
      else $error("event set lost against clear");

   a_flag_hold_idle: assert property (
      (!flag_wr && !cmd_wr && event_set_in == 8'h00) |=> $stable(flags_out))
      else $error("flags changed without event or write");

   a_soft_reset_cmd: assert property (
      (cmd_wr && wr_data_in == CMD_SOFT_RESET)
      |=> (s_pulse_soft and s_pulse_both) and (flags_out == RST_FLAGS))
      else $error("soft reset command mishandled");

   a_prescaler_only: assert property (
      (cmd_wr && wr_data_in == CMD_PRESCALER_CLEAR)
      |=> prescaler_clear_out && !capture_clear_out && !soft_reset_out ##1 !prescaler_clear_out)
      else $error("prescaler clear command mishandled");

   a_capture_only: assert property (
      (cmd_wr && wr_data_in == CMD_CAPTURE_CLEAR)
      |=> capture_clear_out && !prescaler_clear_out && !soft_reset_out)
      else $error("capture clear command mishandled");

   a_both_clears: assert property (
      (cmd_wr && wr_data_in == CMD_BOTH_CLEAR) |=> s_pulse_both and !soft_reset_out)
      else $error("combined clear command mishandled");

   a_unknown_ignored: assert property (
      (cmd_wr && wr_data_in != CMD_SOFT_RESET && wr_data_in != CMD_PRESCALER_CLEAR
       && wr_data_in != CMD_CAPTURE_CLEAR && wr_data_in != CMD_BOTH_CLEAR)
      |=> !soft_reset_out && !prescaler_clear_out && !capture_clear_out)
      else $error("undefined command produced an action");

   a_monitor_read: assert property (
      (rd_en_in && addr_in == ADDR_MINUTES)
      |=> rd_data_out[BIT_EVENT_MONITOR] == (|$past(flags_out)))
      else $error("minutes MSB does not show event monitor");

   a_capture_zeroed: assert property (
      capture_clear_out |-> (st.regs[ADDR_CAPTURE_LO] == 8'h00) && (st.regs[ADDR_CAPTURE_HI] == 8'h00))
      else $error("capture bytes not zero after clear");

   a_alarm_kept: assert property (
      soft_reset_out |-> (st.regs[ADDR_ALARM_LO] == $past(st.regs[ADDR_ALARM_LO]))
                      && (st.regs[ADDR_ALARM_HI] == $past(st.regs[ADDR_ALARM_HI])))
      else $error("alarm bytes changed by reset");

   a_reset_calendar: assert property (
      soft_reset_out |-> (st.regs[ADDR_WEEKDAYS] == RST_WEEKDAYS) && (st.regs[ADDR_DAYS] == RST_DAYS)
                      && (st.regs[ADDR_MONTHS] == RST_MONTHS) && (function_ctrl_out == RST_DEFAULT))
      else $error("calendar defaults wrong after reset");

   a_reset_pins: assert property (
      soft_reset_out |-> (pin_io_out == RST_DEFAULT) && (osc_ctrl_out == RST_DEFAULT)
                      && (battery_switch_out == RST_DEFAULT))
      else $error("pin or supply defaults wrong after reset");

   // ==========================================================
   // Further checks on flags, reads and commands
   // Power-on release: flags clear, both clear pulses standing
   a_power_on_pulse: assert property (
      $fell(reset_in) |-> (flags_out == RST_FLAGS) && prescaler_clear_out && capture_clear_out
                          && !soft_reset_out)
      else $error("power-on reset state or pulses wrong");

   // Every bit written as zero reads back clear
   a_clear_written_zero: assert property (
      (flag_wr && event_set_in == 8'h00)
      |=> ((flags_out & ~$past(wr_data_in)) == 8'h00))
      else $error("flag written zero was not cleared");

   // Writing all ones changes no flag
   a_written_one_keeps: assert property (
      (flag_wr && wr_data_in == 8'hFF)
      |=> (flags_out == ($past(flags_out) | $past(event_set_in))))
      else $error("written one changed a flag");

   // Set flags stay set without a flag write or soft reset
   a_flags_sticky: assert property (
      (!flag_wr && !soft_cmd && !reset_in)
      |=> ((flags_out & $past(flags_out)) == $past(flags_out)))
      else $error("flag dropped without host clear");

   // Any accepted event raises the monitor next cycle
   a_monitor_follows_event: assert property (
      (event_set_in != 8'h00 && !soft_cmd && !reset_in) |=> event_monitor_out)
      else $error("event monitor not raised by event");

   // Flag byte reads back as stored
   a_flag_read_back: assert property (
      (rd_en_in && addr_in == ADDR_EVENT_FLAG) |=> (rd_data_out == $past(flags_out)))
      else $error("flag byte read differs from flags");

   // Soft reset always comes with both clear actions
   a_soft_does_clears: assert property (
      soft_reset_out |-> prescaler_clear_out && capture_clear_out)
      else $error("soft reset without clear actions");

   // Clear commands leave time and flags alone
   a_clear_keeps_time: assert property (
      (cmd_wr && (wr_data_in == CMD_PRESCALER_CLEAR || wr_data_in == CMD_CAPTURE_CLEAR
                  || wr_data_in == CMD_BOTH_CLEAR))
      |=> (st.regs[ADDR_SECONDS] == $past(st.regs[ADDR_SECONDS]))
          && (flags_out == ($past(flags_out) | $past(event_set_in))))
      else $error("clear command disturbed time or flags");

   // No command write, no action pulse
   a_action_needs_cmd: assert property (
      (!cmd_wr && !reset_in) |=> s_no_action)
      else $error("action pulse without command write");

   // Time bytes back at their reset values
   a_reset_time: assert property (
      soft_reset_out |-> (st.regs[ADDR_HUNDREDTHS] == RST_DEFAULT) && (st.regs[ADDR_SECONDS] == RST_SECONDS)
                      && (st.regs[ADDR_MINUTES] == RST_DEFAULT))
      else $error("time bytes wrong after reset");

   // Command byte keeps nothing, reads as zero
   a_cmd_reads_zero: assert property (
      (rd_en_in && addr_in == ADDR_RESET_CMD) |=> (rd_data_out == RST_DEFAULT))
      else $error("command byte read not zero");

endmodule : rtcf_event_flags

`default_nettype wire

// file: sim/rtcf_host_model.sv
// Host controller model driving the byte register port
`timescale 1ns/1ps
`default_nettype none

module rtcf_host_model
(
   input  wire logic                       clk_in,
   output logic                            wr_en_out,
   output logic                            rd_en_out,
   output logic [rtcf_pkg::ADDR_W-1:0]     addr_out,
   output logic [rtcf_pkg::DATA_W-1:0]     wr_data_out
);
   import rtcf_pkg::*;

   // ==========================================================
   // Idle bus at time zero
   initial
   begin
      wr_en_out   = 1'b0;
      rd_en_out   = 1'b0;
      addr_out    = 7'h00;
      wr_data_out = 8'h00;
   end

   // One byte write; released lines show the inverse, not the old value
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      @(posedge clk_in);
      wr_en_out   <= 1'b1;
      addr_out    <= a;
      wr_data_out <= d;
      @(posedge clk_in);
      wr_en_out   <= 1'b0;
      addr_out    <= ~a;
      wr_data_out <= ~d;
   endtask : wr

   // One byte read request
   task automatic rd(input logic [6:0] a);
      @(posedge clk_in);
      rd_en_out <= 1'b1;
      addr_out  <= a;
      @(posedge clk_in);
      rd_en_out <= 1'b0;
      addr_out  <= ~a;
   endtask : rd

   // Command byte sent as a single write
   task automatic cmd(input logic [7:0] c);
      wr(ADDR_RESET_CMD, c);
   endtask : cmd

   // Byte 2Eh, outside the bank and so not stored, is written with 01h before the prescaler clear command
   task automatic clear_prescaler();
      wr(7'h2E, 8'h01);
      cmd(CMD_PRESCALER_CLEAR);
   endtask : clear_prescaler

endmodule : rtcf_host_model
`default_nettype wire

// file: sim/rtcf_event_flags_test.sv
// Self-checking bench for the event flag and reset command block
`timescale 1ns/1ps
`default_nettype none

module rtcf_event_flags_test;
   import rtcf_pkg::*;

   // ==========================================================
   // Signals and bookkeeping
   logic       clk_in = 1'b0;
   logic       reset_in;
   logic [7:0] event_set_in;
   wire logic  wr_en, rd_en;
   wire logic [6:0] addr;
   wire logic [7:0] wdat;
   logic [7:0] rd_data, flags, fc, pio, osc, bat, c, d, d2;
   logic       event_monitor_bit, srst, pclr, cclr;
   logic       rd_pend = 1'b0;
   logic [7:0] exp_q[$];
   int         miscompares = 0;
   int         n_compared = 0;
   int         cycles = 0;
   int         seed_val;
   logic [6:0] ra [0:8] = '{7'h00, 7'h01, 7'h02, 7'h04, 7'h05, 7'h06, 7'h25, 7'h26, 7'h2B};
   logic [7:0] rv [0:8] = '{8'h00, 8'h80, 8'h00, 8'h01, 8'h06, 8'h01, 8'h00, 8'h00, 8'h00};

   rtcf_host_model host (.clk_in(clk_in), .wr_en_out(wr_en), .rd_en_out(rd_en), .addr_out(addr),
                         .wr_data_out(wdat));

   rtcf_event_flags uut (.clk_in(clk_in), .reset_in(reset_in), .wr_en_in(wr_en), .rd_en_in(rd_en),
      .addr_in(addr), .wr_data_in(wdat), .event_set_in(event_set_in), .rd_data_out(rd_data),
      .flags_out(flags), .event_monitor_out(event_monitor_bit), .soft_reset_out(srst), .prescaler_clear_out(pclr),
      .capture_clear_out(cclr), .function_ctrl_out(fc), .pin_io_out(pio), .osc_ctrl_out(osc),
      .battery_switch_out(bat));

   // Clock generator, 20 ns period
   initial
   begin
      forever #10 clk_in = ~clk_in;
   end

   // ==========================================================
   // Helpers
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      n_compared++;
      if (g !== e)
      begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic give_verdict();
      $display("compared %0d, mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : give_verdict

   // Note the expected byte, then ask for the read
   task automatic rd_exp(input logic [6:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      host.rd(a);
   endtask : rd_exp

   // Reset values of the bank and control bytes
   task automatic check_bank();
      for (int i = 0; i < 9; i++)
         rd_exp(ra[i], rv[i]);
      chk("ctrl bytes", 8'h00, fc | pio | osc | bat);
   endtask : check_bank

   // Command, then pulse pattern for one cycle only
   task automatic do_cmd(input logic [7:0] cc);
      if (cc == 8'hA4)
         host.clear_prescaler();
      else
         host.cmd(cc);
      #1;
      chk("pulses", {5'h00, cc == 8'h2C, cc inside {8'h2C, 8'hA4, 8'hA5}, cc inside {8'h2C, 8'h25, 8'hA5}},
          {5'h00, srst, pclr, cclr});
      @(posedge clk_in);
      #1;
      chk("pulses after", 8'h00, {5'h00, srst, pclr, cclr});
   endtask : do_cmd

   // Read monitor against oldest note, plus hang guard
   always @(posedge clk_in)
   begin
      if (rd_pend)
      begin
         if (exp_q.size() == 0)
            chk("unexpected read", 8'h00, 8'hFF);
         else
            chk("rd_data_out", exp_q.pop_front(), rd_data);
      end
      rd_pend <= rd_en;
      cycles++;
      if (cycles == 2000)
      begin
         miscompares++;
         give_verdict();
      end
   end

   // ==========================================================
   // Main sequence
   initial
   begin
      reset_in     <= 1'b1;
      event_set_in <= 8'h00;
      seed_val     = $urandom(32'h811a);
      repeat (3) @(posedge clk_in);
      #1;
      chk("reset pulses", 8'h03, {6'h00, pclr, cclr});
      @(posedge clk_in);
      reset_in <= 1'b0;
      check_bank();
      $display("test reset values done");
      d = 8'h00;
      chk("monitor idle", 8'h00, {7'h00, event_monitor_bit});
      for (int i = 0; i < 8; i++)
      begin
         @(posedge clk_in);
         event_set_in <= 8'h01 << i;
         @(posedge clk_in);
         event_set_in <= 8'h00;
         d[i] = 1'b1;
         #1;
         chk("flags_out", d, flags);
      end
      chk("monitor set", 8'h01, {7'h00, event_monitor_bit});
      rd_exp(ADDR_EVENT_FLAG, 8'hFF);
      rd_exp(ADDR_MINUTES, 8'h80);
      $display("test flag setting done");
      host.wr(ADDR_EVENT_FLAG, 8'hFF);
      rd_exp(ADDR_EVENT_FLAG, 8'hFF);
      d  = 8'($urandom);
      d2 = 8'($urandom);
      host.wr(ADDR_EVENT_FLAG, d);
      host.wr(ADDR_EVENT_FLAG, d2);
      rd_exp(ADDR_EVENT_FLAG, d & d2);
      fork
         host.wr(ADDR_EVENT_FLAG, 8'h00);
         begin
            @(posedge clk_in);
            event_set_in <= 8'h20;
            @(posedge clk_in);
            event_set_in <= 8'h00;
         end
      join
      rd_exp(ADDR_EVENT_FLAG, 8'h20);
      $display("test flag clearing done");
      host.wr(ADDR_SECONDS, 8'h55);
      host.wr(ADDR_ALARM_LO, 8'h5A);
      host.wr(ADDR_ALARM_HI, 8'hA5);
      host.wr(ADDR_CAPTURE_LO, 8'h3C);
      host.wr(ADDR_CAPTURE_HI, 8'hC3);
      do_cmd(8'hA4);
      rd_exp(ADDR_CAPTURE_LO, 8'h3C);
      do_cmd(8'h25);
      rd_exp(ADDR_CAPTURE_LO, 8'h00);
      rd_exp(ADDR_CAPTURE_HI, 8'h00);
      host.wr(ADDR_CAPTURE_HI, 8'hC3);
      do_cmd(8'hA5);
      rd_exp(ADDR_CAPTURE_HI, 8'h00);
      for (int i = 0; i < 4; i++)
      begin
         do c = 8'($urandom); while (c inside {8'h2C, 8'hA4, 8'h25, 8'hA5});
         do_cmd(c);
      end
      rd_exp(ADDR_SECONDS, 8'h55);
      do_cmd(8'h2C);
      chk("monitor cleared", 8'h00, {7'h00, event_monitor_bit});
      check_bank();
      rd_exp(ADDR_ALARM_LO, 8'h5A);
      rd_exp(ADDR_ALARM_HI, 8'hA5);
      host.wr(7'h30, 8'hFF);
      rd_exp(7'h30, 8'h00);
      rd_exp(ADDR_RESET_CMD, 8'h00);
      $display("test commands done");
      repeat (3) @(posedge clk_in);
      chk("reads pending", 8'h00, 8'(exp_q.size()));
      give_verdict();
   end

endmodule : rtcf_event_flags_test
`default_nettype wire
